// ==== asq_analog_model.sv ====
// Purpose: Behavioural far side: input mux, hold capacitor and comparator
// Assumes: comparator answers within the same sys_clk cycle as dac_code
// Notes:   Unpowered comparator output toggles so a stale level never looks valid
`timescale 1ns/1ns

module asq_analog_model (
  input  wire logic         sys_clk,
  input  wire logic [127:0] vin_flat,
  input  wire logic [3:0]   mux_channel,
  input  wire logic         sample_switch_en,
  input  wire logic [7:0]   dac_code,
  input  wire logic         converter_power_up,
  output logic              comp_keep
);
  logic [7:0] held_r;
  logic       junk_r = 1'b0;

  // Hold capacitor follows the routed input only while the switch is closed
  always_ff @(posedge sys_clk) begin
    if (sample_switch_en) held_r <= vin_flat[mux_channel*8 +: 8];
    junk_r <= ~junk_r;
  end

  // Keep the trial bit while input is at or above the trial code
  assign comp_keep = converter_power_up ? (held_r >= dac_code) : junk_r;
endmodule // asq_analog_model

// ==== asq_pkg.sv ====
// Purpose: Shared constants for the eight-bit successive-approximation sequencer
// Assumes: sys_clk is the E clock at 100 MHz; register port is byte wide
// Notes:   Offsets, field positions, reset values and timing counts live here only
package asq_pkg;

  // Clock rate; not referenced anywhere, the cycle counts below are given directly
  localparam int unsigned SYS_CLK_HZ     = 100_000_000;

  // Register map, one byte per address
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  CTRL_OFS       = 3'h0;
  localparam logic [2:0]  RES1_OFS       = 3'h1;
  localparam logic [2:0]  RES2_OFS       = 3'h2;
  localparam logic [2:0]  RES3_OFS       = 3'h3;
  localparam logic [2:0]  RES4_OFS       = 3'h4;
  localparam logic [2:0]  OPTION_OFS     = 3'h5;

  // Control/status register fields
  localparam int          DONE_FLAG_BIT  = 7;
  localparam int          ZERO6_BIT      = 6;
  localparam int          SCAN_BIT       = 5;
  localparam int          MULTI_CH_BIT   = 4;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'h3F;

  // Option register fields
  localparam int          PWR_BIT        = 7;
  localparam int          CLK_SEL_BIT    = 6;
  localparam int          IRQ_EDGE_BIT   = 5;
  localparam int          STOP_DLY_BIT   = 4;
  localparam int          CLK_MON_BIT    = 3;
  localparam int          UNIMP_BIT      = 2;
  localparam logic [7:0]  OPTION_RST     = 8'h10;
  localparam logic [7:0]  OPTION_IMPL    = 8'hFB;
  localparam logic [7:0]  OPTION_PROT    = 8'h33;

  // Conversion slot timing in converter clock ticks
  localparam logic [4:0]  SAMPLE_TICKS   = 5'h0C;
  localparam logic [4:0]  LAST_TICK      = 5'h1F;
  localparam int          SAR_BITS       = 8;
  localparam logic [1:0]  LAST_CONV      = 2'h3;

  // Stop-exit delays and the protected-write window, in E cycles
  localparam int          STOP_FAST_CYC  = 4;
  localparam int          STOP_SLOW_CYC  = 4000;
  localparam logic [6:0]  PROT_WIN_CYC   = 7'h40;

  // Channel codes: 0..7 pins, 8..11 reserved, 12..14 internal, 15 reserved
  localparam logic [3:0]  CH_LAST_PIN    = 4'h7;

  typedef enum logic [1:0] {
    ASQ_IDLE  = 2'b00,
    ASQ_START = 2'b01,
    ASQ_CONV  = 2'b10
  } asq_state_t;

endpackage

// ==== asq_sequencer.sv ====
// Purpose: Digital control of an eight-channel, 8-bit successive-approximation converter
// Assumes: comparator output is produced on sys_clk; the RC oscillator arrives on a pin
// Notes:   Register port answers reads one cycle later; unmapped addresses read zero
`timescale 1ns/1ns

module asq_sequencer
  import asq_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              special_mode,
  input  wire logic              rc_osc_pin,
  input  wire logic              comp_keep,
  input  wire logic              stop_exit_req,
  output logic                   resume_pulse,
  output logic      [3:0]        mux_channel,
  output logic                   sample_switch_en,
  output logic      [7:0]        dac_code,
  output logic                   converter_power_up,
  output logic                   converter_clock_select,
  output logic                   irq_edge_only,
  output logic                   stop_exit_delay_enable,
  output logic                   clock_monitor_enable,
  output logic      [1:0]        watchdog_rate_select
);

  // Reset release through two flip-flops
  logic       rst_meta_r, rst_sync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  logic [7:0] conv_ctrl_status_reg_r;
  logic [7:0] system_option_reg_r;
  logic [7:0] result_r [4];
  logic       conversion_complete_flag_r;
  asq_state_t state_r;
  logic [4:0] tick_r;
  logic [1:0] conv_idx_r;
  logic [7:0] sar_r;
  logic       wr_ctrl, wr_opt, conv_tick, conv_done, group_done;

  // Write decode shared by several processes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] ofs);
    return a == ofs;
  endfunction

  assign wr_ctrl = reg_wr && hit(reg_addr, CTRL_OFS);
  assign wr_opt  = reg_wr && hit(reg_addr, OPTION_OFS);

  // Option fields drive the converter power, clock choice and system options
  assign converter_power_up     = system_option_reg_r[PWR_BIT];
  assign converter_clock_select = system_option_reg_r[CLK_SEL_BIT];
  assign irq_edge_only          = system_option_reg_r[IRQ_EDGE_BIT];
  assign stop_exit_delay_enable = system_option_reg_r[STOP_DLY_BIT];
  assign clock_monitor_enable   = system_option_reg_r[CLK_MON_BIT];
  assign watchdog_rate_select   = system_option_reg_r[1:0];

  // Window for the protected option bits; opened by reset, one write only unless special_mode is set
  logic [6:0] prot_cnt_r;
  logic       prot_used_r;
  logic       prot_open;
  assign prot_open = special_mode || (prot_cnt_r < PROT_WIN_CYC && !prot_used_r);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prot_cnt_r  <= 7'h00;
      prot_used_r <= 1'b0;
    end else begin
      if (prot_cnt_r < PROT_WIN_CYC)
        prot_cnt_r <= prot_cnt_r + 7'h01;
      if (wr_opt && !special_mode)
        prot_used_r <= 1'b1;
    end
  end

  // Option register; bit 2 is never stored so it always reads zero
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_option_reg_r <= OPTION_RST;
    end else if (wr_opt) begin
      system_option_reg_r <= (reg_wdata & OPTION_IMPL & ~OPTION_PROT)
                           | ((prot_open ? reg_wdata : system_option_reg_r)
                              & OPTION_PROT);
    end
  end

  // Control register: channel, scan, multi-channel choice; bits 7:6 are not stored
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      conv_ctrl_status_reg_r <= CTRL_RST;
    else if (wr_ctrl)
      conv_ctrl_status_reg_r <= reg_wdata & CTRL_WR_MASK;
  end

  // RC oscillator pin: three flops, a change counts once the last two agree
  logic [2:0] rc_sync_r;
  logic       rc_level_r, rc_rise;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rc_sync_r  <= 3'h0;
      rc_level_r <= 1'b0;
    end else begin
      rc_sync_r <= {rc_sync_r[1:0], rc_osc_pin};
      if (rc_sync_r[1] == rc_sync_r[2])
        rc_level_r <= rc_sync_r[2];
    end
  end
  assign rc_rise = (rc_sync_r[1] == rc_sync_r[2]) && rc_sync_r[2] && !rc_level_r;

  // Converter tick: every E cycle, or each RC rising edge when selected
  assign conv_tick = converter_clock_select ? rc_rise : 1'b1;

  // Group bookkeeping
  logic multi_ch, scan;
  assign multi_ch   = conv_ctrl_status_reg_r[MULTI_CH_BIT];
  assign scan       = conv_ctrl_status_reg_r[SCAN_BIT];
  assign conv_done  = (state_r == ASQ_CONV) && conv_tick && tick_r == LAST_TICK;
  assign group_done = conv_done && conv_idx_r == LAST_CONV;

  // Sequencer: a write arms START, the next cycle begins conversion 0
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r    <= ASQ_IDLE;
      tick_r     <= 5'h00;
      conv_idx_r <= 2'h0;
    end else if (!converter_power_up) begin
      state_r    <= ASQ_IDLE;
      tick_r     <= 5'h00;
      conv_idx_r <= 2'h0;
    end else if (wr_ctrl) begin
      state_r    <= ASQ_START;
      tick_r     <= 5'h00;
      conv_idx_r <= 2'h0;
    end else begin
      unique case (state_r)
        ASQ_IDLE: begin
          state_r <= ASQ_IDLE;
        end
        ASQ_START: begin
          state_r <= ASQ_CONV;
        end
        ASQ_CONV: begin
          if (conv_tick)
            tick_r <= tick_r + 5'h01;
          if (conv_done) begin
            conv_idx_r <= conv_idx_r + 2'h1;
            if (group_done && !scan)
              state_r <= ASQ_IDLE;
          end
        end
        default: begin
          state_r <= ASQ_IDLE;
        end
      endcase
    end
  end

  // Channel to the multiplexer; multi mode takes the group from the high bits
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      mux_channel <= 4'h0;
    else if (multi_ch)
      mux_channel <= {conv_ctrl_status_reg_r[3:2], conv_idx_r};
    else
      mux_channel <= conv_ctrl_status_reg_r[3:0];
  end

  // Input switch closed only in the first ticks of each slot
  assign sample_switch_en = (state_r == ASQ_CONV) && tick_r < SAMPLE_TICKS;

  // Approximation: even tick sets the trial bit, odd tick keeps or drops it
  logic [4:0] step_tick;
  logic [2:0] bit_sel;
  assign step_tick = tick_r - SAMPLE_TICKS;
  assign bit_sel   = 3'(SAR_BITS - 1) - step_tick[3:1];
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sar_r <= 8'h00;
    end else if (state_r != ASQ_CONV || (conv_tick && tick_r == 5'h00)) begin
      sar_r <= 8'h00;
    end else if (conv_tick && tick_r >= SAMPLE_TICKS && step_tick < 5'h10) begin
      if (!step_tick[0])
        sar_r[bit_sel] <= 1'b1;
      else if (!comp_keep)
        sar_r[bit_sel] <= 1'b0;
    end
  end
  assign dac_code = sar_r;

  // Results: written on the clock edge; the registered read port samples them on a later edge
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 4; i++)
        result_r[i] <= 8'h00;
    end else if (conv_done) begin
      result_r[conv_idx_r] <= sar_r;
    end
  end

  // Completion flag: a finishing group wins over a clearing write
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      conversion_complete_flag_r <= 1'b0;
    else if (group_done)
      conversion_complete_flag_r <= 1'b1;
    else if (wr_ctrl || !converter_power_up)
      conversion_complete_flag_r <= 1'b0;
  end

  // Stop exit: short or long delay before the core resumes
  logic [11:0] stop_cnt_r;
  logic        stop_busy_r;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stop_cnt_r   <= 12'h000;
      stop_busy_r  <= 1'b0;
      resume_pulse <= 1'b0;
    end else begin
      resume_pulse <= 1'b0;
      if (stop_exit_req && !stop_busy_r) begin
        stop_busy_r <= 1'b1;
        stop_cnt_r  <= stop_exit_delay_enable ? 12'(STOP_SLOW_CYC - 1)
                                              : 12'(STOP_FAST_CYC - 2);
      end else if (stop_busy_r) begin
        if (stop_cnt_r == 12'h000) begin
          stop_busy_r  <= 1'b0;
          resume_pulse <= 1'b1;
        end else begin
          stop_cnt_r <= stop_cnt_r - 12'h001;
        end
      end
    end
  end

  // Read port: data in the cycle after the strobe only, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        CTRL_OFS:   reg_rdata <= {conversion_complete_flag_r, 1'b0,
                                  conv_ctrl_status_reg_r[5:0]};
        RES1_OFS:   reg_rdata <= result_r[0];
        RES2_OFS:   reg_rdata <= result_r[1];
        RES3_OFS:   reg_rdata <= result_r[2];
        RES4_OFS:   reg_rdata <= result_r[3];
        OPTION_OFS: reg_rdata <= system_option_reg_r;
        default:    reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks next to the logic
  a_start_after_write: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wr_ctrl && converter_power_up ##1 !wr_ctrl && converter_power_up |->
      state_r == ASQ_START ##1 state_r == ASQ_CONV && tick_r == 5'h00 && conv_idx_r == 2'h0)
    else $error("group did not start one cycle after control write");
  a_flag_cleared: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wr_ctrl && !group_done |=> !conversion_complete_flag_r)
    else $error("completion flag survived a control write");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    group_done |=> conversion_complete_flag_r)
    else $error("completion flag not set after fourth conversion");
  a_sample_window: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    sample_switch_en |-> state_r == ASQ_CONV && tick_r < 5'h0C)
    else $error("input switch closed outside sample window");
  a_result_stored: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_done |=> result_r[$past(conv_idx_r)] == $past(sar_r))
    else $error("result register not loaded from approximation");
  a_single_halts: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    group_done && !scan && !wr_ctrl |=> state_r == ASQ_IDLE ##1 state_r == ASQ_IDLE
      || $past(wr_ctrl))
    else $error("single group did not halt after fourth conversion");
  a_scan_wraps: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    group_done && scan && !wr_ctrl && converter_power_up |=>
      state_r == ASQ_CONV && conv_idx_r == 2'h0)
    else $error("scan did not wrap to first result register");
  a_multi_channel: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    multi_ch |=>
      mux_channel == {$past(conv_ctrl_status_reg_r[3:2]), $past(conv_idx_r)})
    else $error("multi-channel selection wrong");
  a_ctrl_bit6_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    reg_rd && reg_addr == CTRL_OFS |=> !reg_rdata[6]
      && reg_rdata[7] == $past(conversion_complete_flag_r))
    else $error("control register status bits read wrong");
  a_option_bit2: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    reg_rd && reg_addr == OPTION_OFS |=> !reg_rdata[2])
    else $error("option bit 2 read as one");
  a_power_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !converter_power_up |=> state_r == ASQ_IDLE)
    else $error("converter ran while powered down");
  a_protect_locked: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wr_opt && !prot_open |=> (system_option_reg_r & OPTION_PROT)
      == $past(system_option_reg_r & OPTION_PROT))
    else $error("protected option bits changed while locked");
  a_resume_fast: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    stop_exit_req && !stop_busy_r && !stop_exit_delay_enable |-> ##4 resume_pulse)
    else $error("fast stop exit not four cycles");

endmodule // asq_sequencer

// ==== testbench.sv ====
// Purpose: Self-checking bench for the converter sequencer
// Assumes: E clock 100 MHz; RC oscillator pin runs free and unrelated
// Notes:   Expected codes equal the held input, as an ideal comparator gives
`timescale 1ns/1ns

module testbench;
  import asq_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              special_mode = 1'b0;
  logic              rc_osc_pin = 1'b0;
  logic              stop_exit_req = 1'b0;
  logic [7:0]        reg_rdata, dac_code;
  logic [15:0][7:0]  vin;
  logic [3:0]        mux_channel;
  logic [1:0]        watchdog_rate_select;
  logic [127:0]      vin_flat;
  logic              comp_keep, resume_pulse, sample_switch_en, converter_power_up;
  logic              converter_clock_select, irq_edge_only, stop_exit_delay_enable;
  logic              clock_monitor_enable;
  int                bad_count = 0, n_checks = 0, seed, win_cnt = 0, slot_cnt = 0;

  asq_sequencer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .special_mode(special_mode), .rc_osc_pin(rc_osc_pin), .comp_keep(comp_keep),
    .stop_exit_req(stop_exit_req), .resume_pulse(resume_pulse),
    .mux_channel(mux_channel), .sample_switch_en(sample_switch_en), .dac_code(dac_code),
    .converter_power_up(converter_power_up),
    .converter_clock_select(converter_clock_select), .irq_edge_only(irq_edge_only),
    .stop_exit_delay_enable(stop_exit_delay_enable),
    .clock_monitor_enable(clock_monitor_enable),
    .watchdog_rate_select(watchdog_rate_select));

  asq_analog_model u_analog (.sys_clk(sys_clk), .vin_flat(vin_flat),
    .mux_channel(mux_channel), .sample_switch_en(sample_switch_en), .dac_code(dac_code),
    .converter_power_up(converter_power_up), .comp_keep(comp_keep));

  // Packed inputs map straight onto the model's flat bus
  assign vin_flat = vin;

  // Clocks; the RC pin is deliberately off any multiple of the E period
  initial forever #5 sys_clk = ~sys_clk;
  initial forever #31 rc_osc_pin = ~rc_osc_pin;

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; no digital pin reads exist
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [7:0] exp_res(logic [3:0] c, logic m, logic [1:0] k);
    return m ? vin[{c[3:2], k}] : vin[c];
  endfunction

  task automatic wait_flag(input int lim);
    logic [7:0] v;
    int n;
    v = 8'h00;
    n = 0;
    while (v[7] !== 1'b1 && n < lim) begin
      rd(CTRL_OFS, v);
      n++;
    end
    chk("flag_set", 16'(v[7]), 16'h0001);
  endtask

  task automatic run_group(input logic [3:0] c, input logic m, input logic s, input int lim);
    logic [7:0] v;
    wr(CTRL_OFS, {2'b11, s, m, c});
    @(posedge sys_clk);
    #1;
    if (converter_clock_select === 1'b0) begin
      chk("sample_start", 16'(sample_switch_en), 16'h0001);
      chk("mux", 16'(mux_channel), 16'(m ? {c[3:2], 2'b00} : c));
    end
    rd(CTRL_OFS, v);
    chk("ctrl_written", 16'(v), 16'({2'b00, s, m, c}));
    wait_flag(lim);
    rd(CTRL_OFS, v);
    chk("ctrl_done", 16'(v), 16'({2'b10, s, m, c}));
    for (int k = 0; k < 4; k++) begin
      rd(RES1_OFS + 3'(k), v);
      chk("result", 16'(v), 16'(exp_res(c, m, 2'(k))));
    end
  endtask

  task automatic stop_test(input int lo, input int hi);
    int n;
    @(posedge sys_clk);
    stop_exit_req <= 1'b1;
    @(posedge sys_clk);
    stop_exit_req <= 1'b0;
    n = 1;
    #1;
    while (resume_pulse !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("resume_delay", 16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // Sample window length and slot spacing, E clock only
  always @(posedge sys_clk) begin
    slot_cnt <= slot_cnt + 1;
    if (sample_switch_en === 1'b1) begin
      win_cnt <= win_cnt + 1;
      if (win_cnt == 6 && converter_clock_select === 1'b0)
        chk("dac_cleared", 16'(dac_code), 16'h0000);
      if (win_cnt == 0 && slot_cnt > 24 && slot_cnt < 41 && converter_clock_select === 1'b0)
        chk("slot_len", 16'(slot_cnt), 16'h0020);
      if (win_cnt == 0) slot_cnt <= 1;
    end else if (win_cnt != 0) begin
      if (converter_clock_select === 1'b0)
        chk("sample_len", 16'(win_cnt), 16'h000C);
      win_cnt <= 0;
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] v;
    int h;
    seed = 32'hB3C4;
    for (int i = 0; i < 16; i++) vin[i] = 8'($random(seed));
    repeat (16) @(posedge sys_clk);
    #1 chk("rst_outs", 16'({converter_power_up, stop_exit_delay_enable}), 16'h0001);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(OPTION_OFS, v);
    chk("opt_reset", 16'(v), 16'h0010);
    rd(CTRL_OFS, v);
    chk("ctrl_reset", 16'(v), 16'h0000);
    wr(OPTION_OFS, 8'h97);
    wr(OPTION_OFS, 8'h88);
    rd(OPTION_OFS, v);
    chk("opt_once", 16'(v), 16'h009B);
    chk("opt_outs", 16'({converter_power_up, converter_clock_select, irq_edge_only,
      stop_exit_delay_enable, clock_monitor_enable, watchdog_rate_select}), 16'h004F);
    stop_test(3990, 4010);
    wr(3'h6, 8'($random(seed)));
    rd(3'h6, v);
    chk("unmapped6", 16'(v), 16'h0000);
    rd(3'h7, v);
    chk("unmapped7", 16'(v), 16'h0000);
    repeat (10000) @(posedge sys_clk);
    for (int i = 0; i < 20; i++) begin
      if (i < 16) run_group(4'(i), 1'b0, 1'b0, 100);
      else run_group({2'(i - 16), 2'($random(seed))}, 1'b1, 1'b0, 100);
    end
    wr(RES1_OFS, ~vin[12]);
    rd(RES1_OFS, v);
    chk("result_ro", 16'(v), 16'(vin[12]));
    h = 0;
    repeat (100) @(posedge sys_clk) if (sample_switch_en === 1'b1) h++;
    chk("halted", 16'(h), 16'h0000);
    wr(CTRL_OFS, 8'h01);
    repeat (50) @(posedge sys_clk);
    run_group(4'h0, 1'b1, 1'b0, 100);
    run_group(4'h2, 1'b0, 1'b1, 100);
    vin[2] = ~vin[2];
    repeat (250) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      rd(RES1_OFS + 3'(k), v);
      chk("scan_result", 16'(v), 16'(vin[2]));
    end
    special_mode <= 1'b1;
    wr(OPTION_OFS, 8'h07);
    rd(OPTION_OFS, v);
    chk("opt_special", 16'(v), 16'h0003);
    rd(CTRL_OFS, v);
    chk("power_off", 16'({v[7], converter_power_up}), 16'h0000);
    stop_test(1, 6);
    wr(OPTION_OFS, 8'hC0);
    #1;
    chk("clk_sel", 16'(converter_clock_select), 16'h0001);
    repeat (10000) @(posedge sys_clk);
    run_group(4'h5, 1'b0, 1'b0, 1500);
    wrap_up();
  end
endmodule // testbench
